// File: tb/bcd_calendar_clock_regs_properties.sv
// Purpose: Port checks for the calendar clock core
// Assumes: Bound to the core, sees only its ports
// Notes: Quiet means no edge on osc, scl or sda
`timescale 1ns/1ps
`default_nettype none
module bcd_calendar_clock_regs_properties (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic sda_out,
   input wire logic sda_oe,
   input wire logic osc_clk,
   input wire logic wave_pin
);
   reg [3:0] quiet;
   reg       osc_q;
   reg       scl_q;
   reg       sda_q;

   always @(posedge clk_sys) begin
      osc_q <= osc_clk;
      scl_q <= scl_in;
      sda_q <= sda_in;
      if (reset || osc_clk != osc_q || scl_in != scl_q || sda_in != sda_q)
         quiet <= 4'h0;
      else if (quiet != 4'hf)
         quiet <= quiet + 4'h1;
   end

   default clocking @(posedge clk_sys); endclocking
   default disable iff (reset);

   a_sda_out_low: assert property (sda_out == 1'b0)
      else $error("sda_out not low");
   a_reset_quiet: assert property (disable iff (1'b0)
      reset |=> !sda_oe && !wave_pin) else $error("outputs active after reset");
   a_oe_scl_low: assert property ($changed(sda_oe) |-> !scl_in && !$past(scl_in))
      else $error("sda_oe moved while scl high");
   a_ack_stands: assert property ($rose(sda_oe) |=> sda_oe [*6])
      else $error("sda_oe pulse too short");
   a_start_no_ack: assert property (
      scl_in && $past(scl_in) && $fell(sda_in) |=> !sda_oe [*8])
      else $error("drive right after start");
   a_stop_idle: assert property (
      scl_in && $past(scl_in) && $rose(sda_in) |=> !sda_oe [*8])
      else $error("drive right after stop");
   a_quiet_wave: assert property (quiet > 4'h8 |-> $stable(wave_pin))
      else $error("wave moved without cause");
   a_wave_reset_low: assert property ($fell(reset) |-> !wave_pin [*8])
      else $error("wave not idle low after reset");

   c_ack: cover property ($rose(sda_oe));
   c_wave: cover property ($rose(wave_pin));
   c_quiet: cover property (quiet > 4'h8);
endmodule // bcd_calendar_clock_regs_properties

bind bcd_calendar_clock_regs bcd_calendar_clock_regs_properties
   bcd_calendar_clock_regs_properties_inst (.clk_sys(clk_sys), .reset(reset),
   .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
   .osc_clk(osc_clk), .wave_pin(wave_pin));
`default_nettype wire

// File: tb/testbench.sv
// Purpose: Self-checking bench for the calendar clock core
// Assumes: 8 ns system clock, 64 ns oscillator clock
// Notes: Bus runs just under 400 kHz, so one second is not reached
`timescale 1ns/1ps
`default_nettype none
module testbench;
   localparam logic [6:0] DEV_ADDR = 7'h2a; // Arbitrary bus address
   logic clk_sys;
   logic reset;
   logic osc_clk;
   logic osc_run;
   wire  scl;
   wire  sda_low;
   wire  sda_out;
   wire  sda_oe;
   wire  wave_pin;
   wire  sda_line = ~(sda_oe | sda_low);
   int   bad_count;
   int   checks;
   int   cyc;

   bcd_calendar_clock_regs #(.SLAVE_ADDR(DEV_ADDR)) bcd_calendar_clock_regs_inst (
      .clk_sys(clk_sys), .reset(reset), .scl_in(scl), .sda_in(sda_line),
      .sda_out(sda_out), .sda_oe(sda_oe), .osc_clk(osc_clk), .wave_pin(wave_pin));
   two_wire_host #(.ADDR(DEV_ADDR)) two_wire_host_inst (
      .clk(clk_sys), .sda(sda_line), .scl(scl), .sda_low(sda_low));

   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end

   initial begin
      osc_clk = 1'b0;
      #1;
      forever #32 if (osc_run) osc_clk = ~osc_clk;
   end

   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 200000) begin
         bad_count++;
         summarize();
      end
   end

   task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected %s: expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic count_edges(input int n, output int e);
      logic p;
      e = 0;
      p = wave_pin;
      repeat (n) begin
         @(negedge clk_sys);
         if (wave_pin !== p) e++;
         p = wave_pin;
      end
   endtask

   task automatic test_reset();
      logic [7:0] q[$];
      logic [7:0] exp[8];
      exp = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00, 8'h03};
      two_wire_host_inst.read_regs(8'h00, 8, q);
      foreach (exp[i]) check("reset value", exp[i], q[i]);
      $display("done test_reset");
   endtask

   task automatic test_fixed_zero();
      logic [7:0] q[$];
      logic [7:0] exp[6];
      int e;
      exp = '{8'h65, 8'h07, 8'h31, 8'h12, 8'h99, 8'h93};
      two_wire_host_inst.write_regs(8'h42, '{8'he5, 8'hff, 8'hf1, 8'hf2, 8'h99, 8'hff});
      two_wire_host_inst.read_regs(8'h02, 6, q);
      foreach (exp[i]) check("masked value", exp[i], q[i]);
      count_edges(64, e);
      check("wave 32k", 8'h01, {7'h0, e >= 15 && e <= 17});
      $display("done test_fixed_zero");
   endtask

   task automatic test_osc_stop();
      logic [7:0] q[$];
      int e;
      two_wire_host_inst.write_regs(8'h3f, '{8'ha5, 8'h80});
      two_wire_host_inst.read_regs(8'h3f, 2, q);
      check("ram byte", 8'ha5, q[0]);
      check("wrapped seconds", 8'h80, q[1]);
      count_edges(64, e);
      check("stopped wave edges", 8'h00, 8'(e));
      check("stopped wave level", 8'h00, {7'h0, wave_pin});
      osc_run = 1'b0;
      repeat (20) @(negedge clk_sys);
      osc_run = 1'b1;
      two_wire_host_inst.write_regs(8'h00, '{8'h00});
      count_edges(64, e);
      check("restarted wave", 8'h01, {7'h0, e >= 15 && e <= 17});
      $display("done test_osc_stop");
   endtask

   task automatic test_rates();
      logic [7:0] ctl[4];
      int lo[4];
      int hi[4];
      int e;
      ctl = '{8'h11, 8'h12, 8'h10, 8'h80};
      lo = '{7, 15, 0, 0};
      hi = '{9, 17, 1, 0};
      foreach (ctl[i]) begin
         two_wire_host_inst.write_regs(8'h07, '{ctl[i]});
         count_edges(256, e);
         check("wave edges", 8'h01, {7'h0, e >= lo[i] && e <= hi[i]});
      end
      check("idle level", 8'h01, {7'h0, wave_pin});
      $display("done test_rates");
   endtask

   task automatic summarize();
      $display("checks %0d bad_count %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   initial begin
      reset = 1'b1;
      osc_run = 1'b1;
      bad_count = 0;
      checks = 0;
      cyc = 0;
      repeat (3) @(negedge clk_sys);
      reset = 1'b0;
      repeat (4) @(negedge clk_sys);
      test_reset();
      test_fixed_zero();
      test_osc_stop();
      test_rates();
      check("host nacks", 8'h00, 8'(two_wire_host_inst.nacks));
      summarize();
   end
endmodule // testbench
`default_nettype wire

// File: tb/two_wire_host.sv
// Purpose: Bus host model for the two-wire register port
// Assumes: Tasks start just after a falling clk edge
// Notes: sda_low high pulls the open-drain line
`timescale 1ns/1ps
`default_nettype none
module two_wire_host #(
   parameter logic [6:0] ADDR = 7'h2a
) (
   input  wire logic clk,
   input  wire logic sda,
   output var  logic scl,
   output var  logic sda_low
);
   localparam int T_LOW = 170;
   localparam int T_HIGH = 145;
   int nacks;

   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
      nacks = 0;
   end

   task automatic wait_clk(input int n);
      repeat (n) @(negedge clk);
   endtask

   task automatic start();
      wait_clk(5);
      sda_low = 1'b0;
      wait_clk(T_LOW);
      scl = 1'b1;
      wait_clk(T_HIGH);
      sda_low = 1'b1;
      wait_clk(T_HIGH);
      scl = 1'b0;
   endtask

   task automatic stop();
      wait_clk(5);
      sda_low = 1'b1;
      wait_clk(T_LOW);
      scl = 1'b1;
      wait_clk(T_HIGH);
      sda_low = 1'b0;
      wait_clk(T_LOW);
   endtask

   // Data held past the scl fall before it changes
   task automatic clock_bit(input logic b, output logic seen);
      wait_clk(5);
      sda_low = ~b;
      wait_clk(T_LOW);
      scl = 1'b1;
      wait_clk(T_HIGH);
      seen = sda;
      scl = 1'b0;
   endtask

   task automatic send_byte(input logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) clock_bit(d[i], s);
      clock_bit(1'b1, s);
      if (s !== 1'b0) nacks++;
   endtask

   task automatic get_byte(input logic more, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) clock_bit(1'b1, d[i]);
      clock_bit(~more, s);
   endtask

   task automatic write_regs(input logic [7:0] ptr, input logic [7:0] d[$]);
      start();
      send_byte({ADDR, 1'b0});
      send_byte(ptr);
      foreach (d[i]) send_byte(d[i]);
      stop();
   endtask

   task automatic read_regs(input logic [7:0] ptr, input int n, output logic [7:0] q[$]);
      logic [7:0] b;
      q = {};
      start();
      send_byte({ADDR, 1'b0});
      send_byte(ptr);
      start();
      send_byte({ADDR, 1'b1});
      for (int i = 0; i < n; i++) begin
         get_byte(i != n - 1, b);
         q.push_back(b);
      end
      stop();
   endtask
endmodule // two_wire_host
`default_nettype wire

// File: verilog/bcd_calendar_clock_regs.v
// Purpose: Calendar clock core with two-wire register port and wave pin
// Assumes: scl_in, sda_in and osc_clk come from outside clk_sys domain
// Notes: sda is open drain; sda_oe high pulls the line low
// How it works
// R1: Host reads and writes all time and calendar registers any time.
// R2: Year divisible by four makes February 29 days, valid until 2099.
// R3: Wave pin offers 1 Hz, 4.096k, 8.192k, 32.768k when enabled.
// R4: Serial port works with bus clock up to 400 kHz.
// R5: Oscillator disable bit stops oscillator; count chain stays active. Here div and the time registers hold while the bit is set.
// R6: 56 storage bytes at 08 to 3F, plain read and write.
// R7: Only low six address bits decode; 41 reaches 01.
// R8: Fixed zero bits are read only and read back zero.
// R9: BCD layout of seconds, minutes, hours, weekday, date, month, year.
// R10: Hours bit 6 picks 12-hour mode; bit 5 is tens-20 or PM.
// R11: Control at 07: idle level, wave enable, rate; resets to 03.
// R12: Wave disabled drives pin to idle level bit.
// R13: Wave enabled drives pin with square wave at chosen rate.
// R14: At 1 Hz registers update on falling wave edge.
// R15: Rate 00 1 Hz, 01 4.096k, 10 8.192k, 11 32.768k.
// R16: Host clears oscillator disable bit to start timekeeping.
// R17: Date rolls by month length into month; month 12 wraps to 1.
// R18: Weekday counts 1 to 7, steps when hours roll past midnight.
// R19: Write sets pointer then data; reads from pointer; auto-increment.
// R20: Seconds advance every 32768 oscillator cycles, carries ripple up.
`timescale 1ns/1ps
`default_nettype none
`include "rtc_defs.vh"

module bcd_calendar_clock_regs #(
   parameter [6:0] SLAVE_ADDR = `SLAVE_ADDR_DEF  // Arbitrary bus address
) (
   input  wire clk_sys,
   input  wire reset,
   input  wire scl_in,
   input  wire sda_in,
   output reg  sda_out,
   output reg  sda_oe,
   input  wire osc_clk,
   output reg  wave_pin
);

   localparam [4:0] ST_IDLE = 5'h01, ST_RX = 5'h02, ST_ACK = 5'h04;
   localparam [4:0] ST_TX = 5'h08, ST_RACK = 5'h10;
   // Pin synchronisers, third stage for edge finding and, on osc, the 32.768k wave source
   reg [2:0]          scl_s, sda_s, osc_s;
   reg [4:0]          state;
   reg [7:0]          shreg, tx, wr_data;
   reg [3:0]          cnt;
   reg                got_addr, got_ptr, rw, nack, wr_en;
   reg [`ADDR_W-1:0]  ptr;
   reg                osc_dis, mode12, idle_lvl, wave_en;
   reg [6:0]          sec, min;
   reg [5:0]          hr, date;
   reg [2:0]          wday;
   reg [4:0]          mon;
   reg [7:0]          year;
   reg [1:0]          rate;
   reg [`DIV_W-1:0]   div;
   reg [7:0]          ram [0:63];
   // Increments other than weekday kept at byte width, sliced where stored except year
   reg [7:0]          next_sec, next_min, next_hr, next_date, next_mon, next_year;
   reg [2:0]          next_wday;
   reg [5:0]          month_end;
   reg [7:0]          rd_byte;
   reg                next_wave, c_min, c_hr, c_day, c_mon, c_year, leap;
   wire scl_rise = scl_s[1] & ~scl_s[2];
   wire scl_fall = ~scl_s[1] & scl_s[2];
   wire start_c  = scl_s[1] & scl_s[2] & ~sda_s[1] & sda_s[2];
   wire stop_c   = scl_s[1] & scl_s[2] & sda_s[1] & ~sda_s[2];
   wire osc_rise = osc_s[1] & ~osc_s[2];
   wire tick     = osc_rise & ~osc_dis & (div == `DIV_LAST);

   function [7:0] bcd_inc;
      input [7:0] v;
      begin
         if (v[3:0] == `BCD_NINE)
            bcd_inc = {v[7:4] + 4'h1, 4'h0};
         else
            bcd_inc = v + 8'h01;
      end
   endfunction

   always @(posedge clk_sys) begin
      if (reset) begin
         scl_s <= 3'h7;
         sda_s <= 3'h7;
         osc_s <= 3'h0;
      end else begin
         scl_s <= {scl_s[1:0], scl_in};
         sda_s <= {sda_s[1:0], sda_in};
         osc_s <= {osc_s[1:0], osc_clk};
      end
   end

   // Register read view, fixed zero bits forced low
   always @* begin
      case (ptr)
         `REG_SECONDS:  rd_byte = {osc_dis, sec};  // R9
         `REG_MINUTES:  rd_byte = {1'b0, min};  // R8
         `REG_HOURS:    rd_byte = {1'b0, mode12, hr};  // R10
         `REG_WEEKDAY:  rd_byte = {5'h00, wday};  // R8
         `REG_DATE:     rd_byte = {2'h0, date};  // R8
         `REG_MONTH:    rd_byte = {3'h0, mon};  // R8
         `REG_YEAR:     rd_byte = year;
         `REG_WAVE_CTL: rd_byte = {idle_lvl, 2'h0, wave_en, 2'h0, rate};  // R11
         default:       rd_byte = ram[ptr];  // R6
      endcase
   end

   // Carry chain for one second step
   always @* begin
      leap      = (year[1:0] == {year[4], 1'b0});  // R2
      c_min     = (sec == `SEC_LAST);  // R20
      next_sec  = c_min ? 8'h00 : bcd_inc({1'b0, sec});
      c_hr      = c_min & (min == `MIN_LAST);
      next_min  = (min == `MIN_LAST) ? 8'h00 : bcd_inc({1'b0, min});
      if (mode12) begin
         c_day   = hr[`BIT_PM] & (hr[4:0] == `HR12_ELEVEN);
         if (hr[4:0] == `HR12_TWELVE)
            next_hr = {2'h0, hr[`BIT_PM], `HR12_ONE};
         else if (hr[4:0] == `HR12_ELEVEN)
            next_hr = {2'h0, ~hr[`BIT_PM], `HR12_TWELVE};
         else
            next_hr = {2'h0, hr[`BIT_PM], 5'h00} | (bcd_inc({3'h0, hr[4:0]}) & 8'h1f);
      end else begin
         c_day   = (hr == `HR24_LAST);
         next_hr = c_day ? 8'h00 : bcd_inc({2'h0, hr});
      end
      c_day     = c_day & c_hr;
      next_wday = (wday == `WDAY_LAST) ? `WDAY_FIRST : wday + 3'h1;  // R18
      case (mon)
         `MONTH_FEB: month_end = leap ? 6'h29 : 6'h28;  // R2
         5'h04, 5'h06, 5'h09, 5'h11: month_end = 6'h30;
         default: month_end = 6'h31;
      endcase
      c_mon     = c_day & (date == month_end);  // R17
      next_date = (date == month_end) ? {2'h0, `DATE_FIRST} : bcd_inc({2'h0, date});
      c_year    = c_mon & (mon == `MONTH_LAST);
      next_mon  = (mon == `MONTH_LAST) ? {3'h0, `MONTH_FIRST} : bcd_inc({3'h0, mon});
      next_year = (year == `YEAR_LAST) ? 8'h00 : bcd_inc(year);
   end

   // Wave source, 1 Hz falls exactly when the divider wraps
   always @* begin
      case (rate)  // R15
         `RATE_1HZ: next_wave = div[`DIV_BIT_1HZ];
         `RATE_4K:  next_wave = div[`DIV_BIT_4K];
         `RATE_8K:  next_wave = div[`DIV_BIT_8K];
         default:   next_wave = osc_s[2] & ~osc_dis;
      endcase
      if (!wave_en)
         next_wave = idle_lvl;  // R12
   end

   always @(posedge clk_sys) begin
      if (reset)
         wave_pin <= 1'b0;
      else
         wave_pin <= next_wave;  // R13 R3
   end

   // Divider; stopped oscillator means no edges, chain logic stays live
   always @(posedge clk_sys) begin
      if (reset)
         div <= {`DIV_W{1'b0}};
      else if (osc_rise & ~osc_dis)  // R5
         div <= div + 15'h0001;  // R20
   end

   always @(posedge clk_sys) begin
      if (reset) begin
         osc_dis  <= 1'b0;
         sec      <= 7'h00;
         min      <= 7'h00;
         mode12   <= 1'b0;
         hr       <= 6'h00;
         wday     <= `WDAY_FIRST;
         date     <= `DATE_FIRST;
         mon      <= `MONTH_FIRST;
         year     <= 8'h00;
         idle_lvl <= 1'b0;
         wave_en  <= 1'b0;
         rate     <= `RST_RATE;  // R11
      end else begin
         if (tick) begin  // R14
            sec <= next_sec[6:0];
            if (c_min)
               min <= next_min[6:0];
            if (c_hr)
               hr <= next_hr[5:0];
            if (c_day) begin
               wday <= next_wday;  // R18
               date <= next_date[5:0];
            end
            if (c_mon)
               mon <= next_mon[4:0];  // R17
            if (c_year)
               year <= next_year;
         end
         // Host write follows the tick so it wins on a clash
         if (wr_en) begin
            case (ptr)  // R1
               `REG_SECONDS: begin
                  osc_dis <= wr_data[`BIT_OSC_DIS];  // R16
                  sec     <= wr_data[6:0];
               end
               `REG_MINUTES: min <= wr_data[6:0];
               `REG_HOURS: begin
                  mode12 <= wr_data[`BIT_MODE_12H];  // R10
                  hr     <= wr_data[5:0];
               end
               `REG_WEEKDAY: wday <= wr_data[2:0];  // R9
               `REG_DATE:    date <= wr_data[5:0];
               `REG_MONTH:   mon  <= wr_data[4:0];
               `REG_YEAR:    year <= wr_data;
               `REG_WAVE_CTL: begin
                  idle_lvl <= wr_data[`BIT_IDLE_LVL];
                  wave_en  <= wr_data[`BIT_WAVE_EN];
                  rate     <= wr_data[1:0];
               end
               default: ;
            endcase
         end
      end
   end

   always @(posedge clk_sys) begin
      if (wr_en && ptr >= `RAM_FIRST)
         ram[ptr] <= wr_data;  // R6
   end

   // Two-wire slave; oversampled at 125 MHz, fine for 400 kHz bus
   always @(posedge clk_sys) begin
      if (reset) begin
         state    <= ST_IDLE;
         shreg    <= 8'h00;
         tx       <= 8'h00;
         cnt      <= 4'h0;
         got_addr <= 1'b0;
         got_ptr  <= 1'b0;
         rw       <= 1'b0;
         nack     <= 1'b0;
         ptr      <= `REG_SECONDS;
         wr_en    <= 1'b0;
         wr_data  <= 8'h00;
         sda_out  <= 1'b0;
         sda_oe   <= 1'b0;
      end else begin
         wr_en <= 1'b0;
         if (start_c) begin  // R4
            state    <= ST_RX;
            cnt      <= 4'h0;
            got_addr <= 1'b0;
            got_ptr  <= 1'b0;
            sda_oe   <= 1'b0;
         end else if (stop_c) begin
            state  <= ST_IDLE;
            sda_oe <= 1'b0;
         end else begin
            case (state)
               ST_IDLE: ;
               ST_RX: begin
                  if (scl_rise) begin
                     shreg <= {shreg[6:0], sda_s[1]};
                     cnt   <= cnt + 4'h1;
                  end else if (scl_fall && cnt == `BIT_COUNT_FULL) begin
                     cnt   <= 4'h0;
                     state <= ST_ACK;
                     sda_oe <= 1'b1;
                     if (!got_addr) begin
                        if (shreg[7:1] == SLAVE_ADDR) begin
                           got_addr <= 1'b1;
                           rw       <= shreg[0];
                        end else begin
                           state  <= ST_IDLE;
                           sda_oe <= 1'b0;
                        end
                     end else if (!got_ptr) begin
                        got_ptr <= 1'b1;
                        ptr     <= shreg[5:0];  // R7 R19
                     end else begin
                        wr_en   <= 1'b1;
                        wr_data <= shreg;
                     end
                  end
               end
               ST_ACK: begin
                  if (scl_fall) begin
                     if (rw) begin
                        tx     <= rd_byte;  // R19
                        sda_oe <= ~rd_byte[7];
                        cnt    <= 4'h1;
                        ptr    <= ptr + 6'h01;
                        state  <= ST_TX;
                     end else begin
                        sda_oe <= 1'b0;
                        state  <= ST_RX;
                     end
                  end
                  // Data byte stored this cycle, step to the next register
                  if (wr_en)
                     ptr <= ptr + 6'h01;  // R19
               end
               ST_TX: begin
                  if (scl_fall) begin
                     if (cnt == `BIT_COUNT_FULL) begin
                        sda_oe <= 1'b0;
                        state  <= ST_RACK;
                     end else begin
                        tx     <= {tx[6:0], 1'b0};
                        sda_oe <= ~tx[6];
                        cnt    <= cnt + 4'h1;
                     end
                  end
               end
               ST_RACK: begin
                  if (scl_rise)
                     nack <= sda_s[1];
                  else if (scl_fall) begin
                     if (nack)
                        state <= ST_IDLE;
                     else begin
                        tx     <= rd_byte;
                        sda_oe <= ~rd_byte[7];
                        cnt    <= 4'h1;
                        ptr    <= ptr + 6'h01;  // R19
                        state  <= ST_TX;
                     end
                  end
               end
               default: state <= ST_IDLE;
            endcase
         end
      end
   end

endmodule // bcd_calendar_clock_regs

`default_nettype wire

// File: verilog/rtc_defs.vh
// Purpose: Constants for the serial calendar clock core
// Assumes: Included by its bare name
// Notes: Register indices are 6-bit pointer values
`ifndef RTC_DEFS_VH
`define RTC_DEFS_VH

`define ADDR_W          6
`define REG_SECONDS     6'h00
`define REG_MINUTES     6'h01
`define REG_HOURS       6'h02
`define REG_WEEKDAY     6'h03
`define REG_DATE        6'h04
`define REG_MONTH       6'h05
`define REG_YEAR        6'h06
`define REG_WAVE_CTL    6'h07
`define RAM_FIRST       6'h08
`define RAM_LAST        6'h3f

`define BIT_OSC_DIS     7
`define BIT_MODE_12H    6
`define BIT_PM          5
`define BIT_IDLE_LVL    7
`define BIT_WAVE_EN     4

`define RATE_1HZ        2'h0
`define RATE_4K         2'h1
`define RATE_8K         2'h2
`define RATE_32K        2'h3
`define RST_RATE        2'h3

`define DIV_W           15
`define DIV_LAST        15'h7fff
`define DIV_BIT_1HZ     14
`define DIV_BIT_4K      2
`define DIV_BIT_8K      1

`define SEC_LAST        7'h59
`define MIN_LAST        7'h59
`define HR24_LAST       6'h23
`define HR12_ELEVEN     5'h11
`define HR12_TWELVE     5'h12
`define HR12_ONE        5'h01
`define WDAY_LAST       3'h7
`define WDAY_FIRST      3'h1
`define DATE_FIRST      6'h01
`define MONTH_FIRST     5'h01
`define MONTH_LAST      5'h12
`define MONTH_FEB       5'h02
`define YEAR_LAST       8'h99
`define BCD_NINE        4'h9

`define BIT_COUNT_FULL  4'h8
`define SLAVE_ADDR_DEF  7'h51

`endif
